// ### bench/crlg_assertions.sv
// checker for the random level generator outputs
`timescale 1ns/1ps
module crlg_assertions
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic quantized_section_clk,
  input wire logic stored_section_clk,
  input wire logic [7:0] distribution_manual,
  input wire logic [7:0] distribution_atten,
  input wire logic [2:0] level_count,
  input wire logic [2:0] linear_level,
  input wire logic [5:0] exp_level,
  input wire logic [7:0] digital_out,
  input wire logic [7:0] uniform_level,
  input wire logic [7:0] shaped_level
);
  logic [2:0] q_age;
  logic [2:0] s_age;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // cycles since a section clock rose, saturating so it never wraps
  always_ff @(posedge core_clk)
  begin
    q_age <= srst ? 3'h7 : $rose(quantized_section_clk) ? 3'h0 : q_age + {2'h0, q_age != 3'h7};
    s_age <= srst ? 3'h7 : $rose(stored_section_clk) ? 3'h0 : s_age + {2'h0, s_age != 3'h7};
  end
  lvl_range_a: assert property (level_count inside {[1:6]}) else $error("count out of range");
  lin_bound_a: assert property ($changed(linear_level) |-> linear_level <= level_count)
    else $error("linear too high");
  exp_bound_a: assert property ($changed(exp_level) |-> exp_level < (7'h1 << level_count))
    else $error("exp too high");
  q_pair_a: assert property ($changed(linear_level) || $changed(exp_level) |-> $changed(digital_out))
    else $error("levels moved alone");
  q_only_a: assert property ($changed(digital_out) |-> q_age < 3'h5) else $error("bits moved unclocked");
  q_new_a: assert property ($rose(quantized_section_clk) |-> ##[1:4] $changed(digital_out))
    else $error("no new bits");
  s_only_a: assert property ($changed(uniform_level) || $changed(shaped_level) |-> s_age < 3'h5)
    else $error("stored moved unclocked");
  low_bias_a: assert property (($changed(uniform_level) || $changed(shaped_level))
    && $past(distribution_manual) == 8'h00 && $past(distribution_atten) == 8'h00
    |-> shaped_level <= uniform_level) else $error("shaped above uniform at lowest spread");
  rst_vals_a: assert property (disable iff (1'b0) srst |=> level_count == 3'h1 && digital_out == 8'h0)
    else $error("bad reset values");
  cover property ($rose(quantized_section_clk));
  cover property ($rose(stored_section_clk));
  cover property (level_count == 3'h6);
endmodule

bind crlg_top crlg_assertions i_chk (.*);

// ### bench/crlg_clk_src.sv
// external section clock source
`timescale 1ns/1ps
module crlg_clk_src
(
  input wire logic core_clk,
  output logic clk_out
);
  initial clk_out = 1'b0;
  // one gate of any width, idling low so no stray edge
  task automatic gate(input int hi, input int lo);
    repeat (lo) @(negedge core_clk);
    clk_out = 1'b1;
    repeat (hi) @(negedge core_clk);
    clk_out = 1'b0;
  endtask
endmodule

// ### bench/crlg_top_test.sv
// self-checking bench for the random level generator
`timescale 1ns/1ps
module crlg_top_test;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic quantized_section_clk, stored_section_clk;
  logic [2:0] level_count_manual = 3'h0, level_count, linear_level;
  logic [7:0] level_count_control_input = 8'h0, level_count_atten = 8'h0, distribution_manual = 8'h0;
  logic [7:0] distribution_control_input = 8'h0, distribution_atten = 8'h0;
  logic [5:0] exp_level;
  logic [7:0] digital_out, uniform_level, shaped_level, d0;
  logic [7:0] q[$];
  int bad_count = 0, samples_checked = 0, seed = 32'h1d23abbf, nv, sums[2], sumu = 0;
  event look;
  always #2 core_clk = ~core_clk;
  crlg_top i_dut (.*);
  crlg_clk_src i_qsrc (.core_clk(core_clk), .clk_out(quantized_section_clk));
  crlg_clk_src i_ssrc (.core_clk(core_clk), .clk_out(stored_section_clk));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // oldest noted count against the live output
  always @(look)
    check({5'h0, level_count}, q.pop_front(), "count");
  // watchdog, far beyond the expected run
  initial
  begin
    #40000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    check({5'h0, level_count}, 8'h1, "rst count");
    // random counts; controls settle before each gate
    for (int k = 0; k < 12; k++)
    begin
      level_count_manual = 3'($random(seed));
      level_count_control_input = 8'($random(seed));
      level_count_atten = 8'($random(seed));
      nv = level_count_manual + ((int'(level_count_control_input) * level_count_atten >> 8) * 8 >> 8);
      nv = nv < 1 ? 1 : nv > 6 ? 6 : nv;
      q.push_back(8'(nv));
      repeat (3) @(negedge core_clk);
      -> look;
      d0 = digital_out;
      i_qsrc.gate(2 + k % 5, 2);
      repeat (4) @(negedge core_clk);
      check(8'(digital_out !== d0), 8'h1, "bits new");
      check({5'h0, linear_level}, 8'((int'(digital_out) * (nv + 1)) >> 8), "linear");
      check({2'h0, exp_level}, 8'(int'(digital_out) & ((1 << nv) - 1)), "exp");
    end
    // lowest then highest distribution, summing shaped draws
    for (int k = 0; k < 2; k++)
    begin
      {distribution_manual, distribution_control_input, distribution_atten} = k ? 24'hFFFFFF : 24'h0;
      sums[k] = 0;
      repeat (16)
      begin
        i_ssrc.gate(2, 3);
        repeat (4) @(negedge core_clk);
        sums[k] += shaped_level;
        sumu += uniform_level;
      end
    end
    check(8'(sums[0] < 2048), 8'h1, "low bias");
    check(8'(sums[0] < sums[1]), 8'h1, "shift high");
    check(8'(sumu > 1024 && sumu < 7168), 8'h1, "uniform spread");
    wrap_up;
  end
endmodule

// ### core/crlg_edge_sync.sv
// two-stage synchroniser with rising edge pulse
`timescale 1ns/1ps
module crlg_edge_sync
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic rise_pulse
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // meta feeds only sync; the edge test looks at sync and prev
  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign rise_pulse = sync & ~prev;
endmodule

// ### core/crlg_top.sv
// clocked random level generator: quantized and stored sections
`timescale 1ns/1ps
// Function
// - level count held within one to six
// - count is manual plus attenuated control
// - linear output has count plus one levels
// - exponential output has two-power-count levels
// - quantized clock edge refreshes both outputs
// - eight-bit shift register drives random values
// - digital outputs mirror shift register
// - each quantized edge gives new bit pattern
// - any bit may stay or change
// - stored clock edge refreshes both outputs
// - uniform and shaped outputs, 256 levels
// - minimum distribution favours low values
// - larger distribution moves weight toward high
// - distribution is manual plus attenuated control
module crlg_top
#(
  parameter int CTL_BITS = crlg_pkg::CTL_W
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic quantized_section_clk,
  input wire logic stored_section_clk,
  input wire logic [2:0] level_count_manual,
  input wire logic [CTL_BITS-1:0] level_count_control_input,
  input wire logic [CTL_BITS-1:0] level_count_atten,
  input wire logic [7:0] distribution_manual,
  input wire logic [CTL_BITS-1:0] distribution_control_input,
  input wire logic [CTL_BITS-1:0] distribution_atten,
  output logic [2:0] level_count,
  output logic [2:0] linear_level,
  output logic [5:0] exp_level,
  output logic [7:0] digital_out,
  output logic [7:0] uniform_level,
  output logic [7:0] shaped_level
);
  import crlg_pkg::*;

  // generator, shift register and the combinational next values
  logic [LFSR_W-1:0] lfsr;
  logic [LFSR_W-1:0] next_lfsr;
  logic [SR_W-1:0] shreg;
  logic [SR_W-1:0] next_shreg;
  logic [LIN_W-1:0] next_linear;
  logic [EXP_W-1:0] next_exp;
  logic [STO_W-1:0] next_uniform;
  logic [STO_W-1:0] next_shaped;
  logic [N_W-1:0] n_eff;
  logic [D_W-1:0] d_eff;
  logic q_pulse;
  logic s_pulse;

  // each section clock gets its own synchroniser; the sections never share a pulse
  crlg_edge_sync u_qsync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(quantized_section_clk),
    .rise_pulse(q_pulse)
  );

  // edges closer than two core cycles apart may be lost here
  crlg_edge_sync u_ssync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(stored_section_clk),
    .rise_pulse(s_pulse)
  );

  // attenuated control: product scaled back to control width
  // a full attenuator setting passes just under the raw value
  function automatic logic [CTL_BITS-1:0] atten(input logic [CTL_BITS-1:0] v, input logic [CTL_BITS-1:0] a);
    logic [2*CTL_BITS-1:0] p;
    p = v * a;
    return p[2*CTL_BITS-1:CTL_BITS];
  endfunction

  // level count: control adds up to 7 steps, clamped to 1..6
  // a manual setting of 0 or 7 is pulled back into range as well
  always_comb
  begin
    logic [CTL_BITS+1:0] sum;
    sum = '0;
    sum = (CTL_BITS+2)'(level_count_manual)
      + (CTL_BITS+2)'({atten(level_count_control_input, level_count_atten), 3'h0} >> CTL_BITS);
    if (sum < (CTL_BITS+2)'(N_MIN))
      n_eff = N_MIN;
    else if (sum > (CTL_BITS+2)'(N_MAX))
      n_eff = N_MAX;
    else
      n_eff = sum[N_W-1:0];
  end

  // distribution: saturating sum keeps the knob monotonic
  // limitation: the combined range tops out at 509, below D_MAX, so the top never flattens or wraps
  always_comb
  begin
    logic [D_W:0] dsum;
    dsum = '0;
    dsum = (D_W+1)'(distribution_manual)
      + (D_W+1)'(atten(distribution_control_input, distribution_atten));
    d_eff = dsum[D_W] ? D_MAX : dsum[D_W-1:0];
  end

  // lfsr steps every cycle, so edge timing adds entropy
  // an all-zero state would lock the generator, so it reloads the seed
  always_comb
  begin
    if (lfsr == '0)
      next_lfsr = LFSR_SEED;
    else
      next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
  end

  // quantized section: 8 fresh bits from the lfsr on each edge
  always_comb
  begin
    next_shreg = shreg;
    next_linear = linear_level;
    next_exp = exp_level;
    // outside an edge every value simply holds
    if (q_pulse)
    begin
      // a repeat of the old pattern is inverted so every edge moves the bits
      if (lfsr[SR_W-1:0] == shreg)
        next_shreg = ~shreg;
      else
        next_shreg = lfsr[SR_W-1:0];
      // modulo n+1 via scaling keeps result within 0..n
      next_linear = LIN_W'((16'(next_shreg) * (16'(n_eff) + 16'h1)) >> SR_W);
      // exp keeps the low count bits of the pattern
      next_exp = EXP_W'(next_shreg[EXP_W-1:0] & EXP_W'((7'h01 << n_eff) - 7'h01));
    end
  end

  // stored section: shaped value uses min/max of two draws
  // lo and hi come from the two halves of one generator word
  always_comb
  begin
    logic [STO_W-1:0] a;
    logic [STO_W-1:0] b;
    logic [STO_W-1:0] lo;
    logic [STO_W-1:0] hi;
    logic [16:0] mix;
    a = lfsr[15:8];
    b = lfsr[7:0];
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    mix = '0;
    next_uniform = uniform_level;
    next_shaped = shaped_level;
    if (s_pulse)
    begin
      // the upper draw goes out unchanged as the uniform value
      next_uniform = a;
      // d=0 gives min draw (low bias), max gives max draw (high bias)
      mix = 17'(lo) * 17'(D_MAX - d_eff) + 17'(hi) * 17'(d_eff);
      next_shaped = STO_W'(mix / 17'(D_MAX));
    end
  end

  // generator state
  always_ff @(posedge core_clk)
  begin
    if (srst)
      lfsr <= LFSR_SEED;
    else
      lfsr <= next_lfsr;
  end

  // quantized section state; outputs hold until the next edge
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      shreg <= '0;
      linear_level <= '0;
      exp_level <= '0;
    end
    else
    begin
      shreg <= next_shreg;
      linear_level <= next_linear;
      exp_level <= next_exp;
    end
  end

  // stored section state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      uniform_level <= '0;
      shaped_level <= '0;
    end
    else
    begin
      uniform_level <= next_uniform;
      shaped_level <= next_shaped;
    end
  end

  // effective count is shown every cycle, not only on an edge
  always_ff @(posedge core_clk)
  begin
    if (srst)
      level_count <= N_MIN;
    else
      level_count <= n_eff;
  end

  // one digital output per register bit
  for (genvar i = 0; i < SR_W; i++)
  begin : g_bit
    assign digital_out[i] = shreg[i];
  end
endmodule

// ### pkg/crlg_pkg.sv
// constants for the clocked random level generator
package crlg_pkg;
  localparam int LFSR_W = 16;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int SR_W = 8;
  localparam int N_W = 3;
  localparam logic [2:0] N_MIN = 3'h1;
  localparam logic [2:0] N_MAX = 3'h6;
  localparam int CTL_W = 8;
  localparam int LIN_W = 3;
  localparam int EXP_W = 6;
  localparam int STO_W = 8;
  localparam int D_W = 9;
  localparam logic [8:0] D_MAX = 9'h1FF;
endpackage
